//--- shared/qio_read_pkg.sv
// constants for the quad-line flash read engine
package qio_read_pkg;

  // instruction codes
  localparam logic [7:0] CMD_FAST_QUAD_READ = 8'heb;
  localparam logic [7:0] CMD_WORD_QUAD_READ = 8'he7;
  localparam logic [7:0] CMD_OCTAL_QUAD_READ = 8'he3;
  localparam logic [7:0] CMD_SET_BURST_WRAP = 8'h77;
  localparam logic [7:0] CMD_MODE_RESET = 8'hff;

  // phase lengths in serial clocks
  localparam logic [4:0] CMD_CLOCKS = 5'h08;
  localparam logic [4:0] ADDR_CLOCKS = 5'h06;
  localparam logic [4:0] MODE_CLOCKS = 5'h02;
  localparam logic [4:0] WRAP_CMD_CLOCKS = 5'h08;
  localparam logic [4:0] DUMMY_FAST_QUAD = 5'h04;
  localparam logic [4:0] DUMMY_WORD_QUAD = 5'h02;
  localparam logic [4:0] DUMMY_OCTAL_QUAD = 5'h00;

  // continuous-read mode reset lengths
  localparam logic [4:0] QUAD_MODE_RESET_CLOCKS = 5'h08;
  localparam logic [4:0] DUAL_MODE_RESET_CLOCKS = 5'h10;
  localparam logic [4:0] CLOCK_COUNT_MAX = 5'h1f;

  // continuous-read mode byte fields
  localparam logic [1:0] CODE_SKIP_VALUE = 2'h2;
  localparam int CODE_SKIP_LSB = 4;

  // burst wrap setting fields
  localparam int WRAP_DISABLE_POS = 4;
  localparam int WRAP_LENGTH_LSB = 5;
  localparam logic WRAP_DISABLE_RESET = 1'h1;
  localparam logic [1:0] WRAP_LENGTH_RESET = 2'h0;
  localparam logic [7:0] WRAP_BASE_BYTES = 8'h08;

  // address and memory geometry
  localparam int ADDR_BITS = 24;
  localparam int MEM_ADDR_BITS_DEFAULT = 10;

  // system clock, 10 MHz
  localparam int CLK_PERIOD_NS = 100;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_WRAP,
    ST_IGNORE
  } engine_state_e;

endpackage : qio_read_pkg

//--- core/flash_array.sv
// byte-wide storage array with registered read data
`timescale 1ns/100ps
module flash_array #(
  parameter int ADDR_W = 10
) (
  // clock
  input wire logic clk,
  // load port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] memCells [0:(1<<ADDR_W)-1];
  logic [7:0] rdData_q;

  // no reset on the array so it maps onto block ram
  always_ff @(posedge clk) begin
    if (wrEn) begin
      memCells[wrAddr] <= wrData;
    end
    rdData_q <= memCells[rdAddr];
  end

  assign rdData = rdData_q;

endmodule : flash_array

//--- core/quad_io_flash_read_engine.sv
// device-side quad-line read engine with continuous mode and burst wrap
//
// Summary of operation
// (R1) fast quad read: quad address, four dummies
// (R2) quad reads need quad enable bit set; engine skips the check for continuous-mode cycles
// (R3) mode byte follows address; low nibble ignored
// (R4) skip pair 10: next cycle starts at address
// (R5) other skip pair: next cycle needs instruction
// (R6) host releases lines before first data edge
// (R7) mode reset clears stored continuous mode
// (R8) wrap within selected section until deselect
// (R9) latest wrap setting applies to later reads
// (R10) wrap bit 4 disables; bits 6:5 length
// (R11) word quad read: even address, two dummies
// (R12) octal read: 16-aligned address, no dummies
// (R13) continuous mode covers word and octal reads
// (R14) wrap command: 24 ignored bits, wrap byte
// (R15) wrap disable bit comes up set
// (R16) mode reset: eight or sixteen clocks of ones
// (R17) six address clocks, two mode, msb first
// (R18) no wrap: increment and stream while selected
`timescale 1ns/100ps
module quad_io_flash_read_engine
  import qio_read_pkg::*;
#(
  parameter int MEM_ADDR_BITS = MEM_ADDR_BITS_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link, sampled on clk
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic [3:0] quadLineIn,
  output logic [3:0] quadLineOut,
  output logic [3:0] quadLineOe,
  // configuration
  input wire logic quadLinesEnableBit,
  // status
  output logic continuousModeActive,
  output logic wrapDisableBit,
  output logic [1:0] wrapLengthBits,
  output logic readStreaming,
  // array load port
  input wire logic loadEn,
  input wire logic [MEM_ADDR_BITS-1:0] loadAddr,
  input wire logic [7:0] loadData
);

  engine_state_e state_q, state_d;
  logic [4:0] phaseCount_q, phaseCount_d;
  logic [4:0] clockCount_q, clockCount_d;
  logic allOnes_q, allOnes_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] activeCmd_q, activeCmd_d;
  logic [ADDR_BITS-1:0] readAddressBits_q, readAddressBits_d;
  logic [7:0] continuousReadModeByte_q, continuousReadModeByte_d;
  logic continuousMode_q, continuousMode_d;
  logic [7:0] continuousCmd_q, continuousCmd_d;
  logic wrapDisable_q, wrapDisable_d;
  logic [1:0] wrapLength_q, wrapLength_d;
  logic nibbleLow_q, nibbleLow_d;
  logic [3:0] lineOut_q, lineOut_d;
  logic [3:0] lineOe_q, lineOe_d;
  logic streaming_q, streaming_d;
  logic spiClkPrev_q;

  logic clkRise;
  logic clkFall;
  logic [7:0] rdByte;
  logic [7:0] cmdByte;
  logic [7:0] modeByteFull;
  logic [7:0] wrapByteFull;
  logic isQuadRead;
  logic [4:0] dummyClocks;
  logic [7:0] wrapMask;
  logic [7:0] lowNext;
  logic [ADDR_BITS-1:0] nextAddress;

  flash_array #(
    .ADDR_W(MEM_ADDR_BITS)
  ) u_array (
    .clk(clk),
    .wrEn(loadEn),
    .wrAddr(loadAddr),
    .wrData(loadData),
    .rdAddr(readAddressBits_q[MEM_ADDR_BITS-1:0]),
    .rdData(rdByte)
  );

  // serial clock edges seen by the system clock
  always_comb begin
    clkRise = spiClk & ~spiClkPrev_q;
    clkFall = ~spiClk & spiClkPrev_q;
  end

  // (R17) instruction msb first on line 0
  always_comb begin
    cmdByte = {shift_q[6:0], quadLineIn[0]};
    modeByteFull = {continuousReadModeByte_q[3:0], quadLineIn};
    wrapByteFull = {shift_q[3:0], quadLineIn};
  end

  // (R2) quad enable gates instruction-started quad reads only, not continuous-mode cycles
  always_comb begin
    isQuadRead = quadLinesEnableBit &&
                 ((cmdByte == CMD_FAST_QUAD_READ) ||
                  (cmdByte == CMD_WORD_QUAD_READ) ||
                  (cmdByte == CMD_OCTAL_QUAD_READ));
  end

  // (R1) dummy clocks per command
  always_comb begin
    if (activeCmd_q == CMD_WORD_QUAD_READ) begin
      // (R11) word read two dummies
      dummyClocks = DUMMY_WORD_QUAD;
    end else if (activeCmd_q == CMD_OCTAL_QUAD_READ) begin
      // (R12) octal read no dummies
      dummyClocks = DUMMY_OCTAL_QUAD;
    end else begin
      dummyClocks = DUMMY_FAST_QUAD;
    end
  end

  // (R8) wrap inside the selected section
  always_comb begin
    wrapMask = 8'((WRAP_BASE_BYTES << wrapLength_q) - 8'h01);
    lowNext = 8'(readAddressBits_q[7:0] + 8'h01);
    if (!wrapDisable_q) begin
      nextAddress = {readAddressBits_q[ADDR_BITS-1:8],
                     (readAddressBits_q[7:0] & ~wrapMask) | (lowNext & wrapMask)};
    end else begin
      // (R18) plain increment
      nextAddress = ADDR_BITS'(readAddressBits_q + 24'h000001);
    end
  end

  always_comb begin
    state_d = state_q;
    phaseCount_d = phaseCount_q;
    clockCount_d = clockCount_q;
    allOnes_d = allOnes_q;
    shift_d = shift_q;
    activeCmd_d = activeCmd_q;
    readAddressBits_d = readAddressBits_q;
    continuousReadModeByte_d = continuousReadModeByte_q;
    continuousMode_d = continuousMode_q;
    continuousCmd_d = continuousCmd_q;
    wrapDisable_d = wrapDisable_q;
    wrapLength_d = wrapLength_q;
    nibbleLow_d = nibbleLow_q;
    lineOut_d = lineOut_q;
    lineOe_d = lineOe_q;
    if (chipSelectN) begin
      // deselect ends any burst and frees the lines at once
      state_d = ST_IDLE;
      phaseCount_d = 5'h00;
      clockCount_d = 5'h00;
      allOnes_d = 1'b1;
      lineOe_d = 4'h0;
      nibbleLow_d = 1'b0;
      // (R16) eight or sixteen clocks of ones
      if (state_q != ST_IDLE && continuousMode_q && allOnes_q &&
          (clockCount_q == QUAD_MODE_RESET_CLOCKS ||
           clockCount_q == DUAL_MODE_RESET_CLOCKS)) begin
        // (R7) mode reset clears continuous mode
        continuousMode_d = 1'b0;
      end
    end else if (clkRise) begin
      if (clockCount_q != CLOCK_COUNT_MAX) begin
        clockCount_d = 5'(clockCount_q + 5'h01);
      end
      // dual reset drives ones on the two low lines only
      if (quadLineIn[1:0] != 2'h3) begin
        allOnes_d = 1'b0;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (continuousMode_q) begin
            // (R4) address comes first, no instruction
            // (R13) same for word and octal reads
            activeCmd_d = continuousCmd_q;
            readAddressBits_d = {readAddressBits_q[ADDR_BITS-5:0], quadLineIn};
            phaseCount_d = 5'h01;
            state_d = ST_ADDR;
          end else begin
            // (R5) normal cycle starts with instruction
            shift_d = {7'h00, quadLineIn[0]};
            phaseCount_d = 5'h01;
            state_d = ST_CMD;
          end
        end
        ST_CMD: begin
          shift_d = cmdByte;
          phaseCount_d = 5'(phaseCount_q + 5'h01);
          if (phaseCount_q == CMD_CLOCKS - 5'h01) begin
            phaseCount_d = 5'h00;
            if (isQuadRead) begin
              activeCmd_d = cmdByte;
              state_d = ST_ADDR;
            end else if (cmdByte == CMD_SET_BURST_WRAP) begin
              state_d = ST_WRAP;
            end else begin
              // mode reset outside continuous mode lands here too
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          // (R17) six address nibbles, msb first
          readAddressBits_d = {readAddressBits_q[ADDR_BITS-5:0], quadLineIn};
          phaseCount_d = 5'(phaseCount_q + 5'h01);
          if (phaseCount_q == ADDR_CLOCKS - 5'h01) begin
            phaseCount_d = 5'h00;
            state_d = ST_MODE;
          end
        end
        ST_MODE: begin
          // (R3) two mode nibbles, low nibble unused
          continuousReadModeByte_d = modeByteFull;
          phaseCount_d = 5'(phaseCount_q + 5'h01);
          if (phaseCount_q == MODE_CLOCKS - 5'h01) begin
            phaseCount_d = 5'h00;
            // (R4) skip pair selects continuous mode
            continuousMode_d =
              (modeByteFull[CODE_SKIP_LSB+:2] == CODE_SKIP_VALUE);
            continuousCmd_d = activeCmd_q;
            nibbleLow_d = 1'b0;
            state_d = (dummyClocks == 5'h00) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          phaseCount_d = 5'(phaseCount_q + 5'h01);
          if (phaseCount_q == dummyClocks - 5'h01) begin
            phaseCount_d = 5'h00;
            state_d = ST_DATA;
          end
        end
        ST_WRAP: begin
          // (R14) six ignored clocks then wrap byte
          shift_d = wrapByteFull;
          phaseCount_d = 5'(phaseCount_q + 5'h01);
          if (phaseCount_q == WRAP_CMD_CLOCKS - 5'h01) begin
            // (R9) kept for every later read
            // (R10) bit 4 disables, bits 6:5 length
            wrapDisable_d = wrapByteFull[WRAP_DISABLE_POS];
            wrapLength_d = wrapByteFull[WRAP_LENGTH_LSB+:2];
            state_d = ST_IGNORE;
          end
        end
        ST_DATA: begin
          // data phase only reacts to falling edges
          state_d = ST_DATA;
        end
        ST_IGNORE: begin
          state_d = ST_IGNORE;
        end
      endcase
    end else if (clkFall && state_q == ST_DATA) begin
      // (R6) device drives from first falling edge of data
      lineOe_d = 4'hf;
      lineOut_d = nibbleLow_q ? rdByte[3:0] : rdByte[7:4];
      nibbleLow_d = ~nibbleLow_q;
      if (nibbleLow_q) begin
        // (R18) next byte fetched while selected
        readAddressBits_d = nextAddress;
      end
    end
  end

  always_comb begin
    streaming_d = (state_d == ST_DATA);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      phaseCount_q <= 5'h00;
      clockCount_q <= 5'h00;
      allOnes_q <= 1'b1;
      shift_q <= 8'h00;
      activeCmd_q <= 8'h00;
      readAddressBits_q <= 24'h000000;
      continuousReadModeByte_q <= 8'h00;
      continuousMode_q <= 1'b0;
      continuousCmd_q <= 8'h00;
      // (R15) wrap off after power-up
      wrapDisable_q <= WRAP_DISABLE_RESET;
      wrapLength_q <= WRAP_LENGTH_RESET;
      nibbleLow_q <= 1'b0;
      lineOut_q <= 4'h0;
      lineOe_q <= 4'h0;
      streaming_q <= 1'b0;
      spiClkPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phaseCount_q <= phaseCount_d;
      clockCount_q <= clockCount_d;
      allOnes_q <= allOnes_d;
      shift_q <= shift_d;
      activeCmd_q <= activeCmd_d;
      readAddressBits_q <= readAddressBits_d;
      continuousReadModeByte_q <= continuousReadModeByte_d;
      continuousMode_q <= continuousMode_d;
      continuousCmd_q <= continuousCmd_d;
      wrapDisable_q <= wrapDisable_d;
      wrapLength_q <= wrapLength_d;
      nibbleLow_q <= nibbleLow_d;
      lineOut_q <= lineOut_d;
      lineOe_q <= lineOe_d;
      streaming_q <= streaming_d;
      spiClkPrev_q <= spiClk;
    end
  end

  // all outputs come straight from flops
  assign quadLineOut = lineOut_q;
  assign quadLineOe = lineOe_q;
  assign continuousModeActive = continuousMode_q;
  assign wrapDisableBit = wrapDisable_q;
  assign wrapLengthBits = wrapLength_q;
  assign readStreaming = streaming_q;

endmodule : quad_io_flash_read_engine

//--- verification/qio_read_props.sv
// port assertions for the quad-line read engine
`timescale 1ns/100ps
module qio_read_props #(
  parameter int MEM_ADDR_BITS = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic [3:0] quadLineOut,
  input wire logic [3:0] quadLineOe,
  // status
  input wire logic quadLinesEnableBit,
  input wire logic continuousModeActive,
  input wire logic wrapDisableBit,
  input wire logic [1:0] wrapLengthBits,
  input wire logic readStreaming
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_fall; spiClk ##1 !spiClk; endsequence
  sequence s_sel; !chipSelectN && readStreaming; endsequence
  property p_oe_on; s_fall ##0 s_sel |=> quadLineOe == 4'hf; endproperty
  property p_oe_off; chipSelectN |=> quadLineOe == 4'h0; endproperty
  property p_oe_all; quadLineOe != 4'h0 |-> quadLineOe == 4'hf && readStreaming; endproperty
  property p_end; readStreaming && chipSelectN |=> !readStreaming; endproperty
  property p_out;
    $changed(quadLineOut) && quadLineOe == 4'hf && $past(quadLineOe) == 4'hf
      |-> $past(spiClk, 2) && !$past(spiClk);
  endproperty
  property p_qe; $rose(readStreaming) && !continuousModeActive |-> quadLinesEnableBit; endproperty
  property p_cont; $rose(continuousModeActive) |-> !$past(chipSelectN); endproperty
  property p_wrap;
    $changed({wrapDisableBit, wrapLengthBits}) |-> !$past(chipSelectN) && $past(spiClk);
  endproperty
  property p_rst;
    $past(srst) |-> wrapDisableBit && wrapLengthBits == 2'h0 && !continuousModeActive;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("no drive after fall");
  a_oe_off: assert property (p_oe_off) else $error("drive while deselected");
  a_oe_all: assert property (p_oe_all) else $error("partial drive");
  a_end: assert property (p_end) else $error("stream past deselect");
  a_out: assert property (p_out) else $error("data moved off fall");
  a_qe: assert property (p_qe) else $error("read without quad enable");
  a_cont: assert property (p_cont) else $error("skip mode set idle");
  a_wrap: assert property (p_wrap) else $error("wrap moved idle");
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule : qio_read_props

bind quad_io_flash_read_engine qio_read_props #(.MEM_ADDR_BITS(MEM_ADDR_BITS)) props (
  .clk(clk), .srst(srst), .spiClk(spiClk), .chipSelectN(chipSelectN),
  .quadLineOut(quadLineOut), .quadLineOe(quadLineOe), .quadLinesEnableBit(quadLinesEnableBit),
  .continuousModeActive(continuousModeActive), .wrapDisableBit(wrapDisableBit),
  .wrapLengthBits(wrapLengthBits), .readStreaming(readStreaming));

//--- verification/qspi_host_model.sv
// behavioural quad host driving the read engine
`timescale 1ns/100ps
module qspi_host_model (
  // clock
  input wire logic clk,
  // device drive
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe,
  // link
  output logic spiClk,
  output logic chipSelectN,
  output logic [3:0] lineIn
);
  logic [3:0] hostOut = 4'h0;
  logic [3:0] lastVal = 4'h0;
  logic hostOe = 1'b0;
  logic [7:0] got [$];
  initial begin
    spiClk = 1'b0;
    chipSelectN = 1'b1;
  end
  // released lines toggle so a stale level never reads as data
  always @(posedge clk) lastVal <= lineIn;
  always_comb begin
    for (int i = 0; i < 4; i++) lineIn[i] = devOe[i] ? devOut[i] : hostOe ? hostOut[i] : ~lastVal[i];
  end
  task automatic tick(input logic [3:0] v, input bit drv, input bit rel, output logic [3:0] s);
    @(negedge clk);
    spiClk = 1'b0;
    hostOut = v;
    hostOe = drv;
    repeat (4) @(negedge clk);
    s = lineIn;
    spiClk = 1'b1;
    repeat (2) @(negedge clk);
    if (rel) hostOe = 1'b0;
    repeat (2) @(negedge clk);
  endtask : tick
  task automatic close();
    @(negedge clk);
    spiClk = 1'b0;
    repeat (2) @(negedge clk);
    chipSelectN = 1'b1;
    hostOe = 1'b0;
    repeat (4) @(negedge clk);
  endtask : close
  task automatic frame(input bit useCmd, input logic [7:0] cmd, input logic [23:0] adr,
      input logic [7:0] mode, input int dum, input int nb);
    logic [3:0] s, hi;
    got.delete();
    @(negedge clk);
    chipSelectN = 1'b0;
    // instruction on line 0, then msb-first nibbles
    if (useCmd) for (int i = 7; i >= 0; i--) tick({3'h0, cmd[i]}, 1, 0, s);
    for (int i = 5; i >= 0; i--) tick(adr[i*4+:4], 1, 0, s);
    tick(mode[7:4], 1, 0, s);
    tick(mode[3:0], 1, dum == 0, s);
    for (int i = 0; i < dum; i++) tick(4'h0, 1, i == dum - 1, s);
    for (int i = 0; i < nb; i++) begin
      tick(4'h0, 0, 0, hi);
      tick(4'h0, 0, 0, s);
      got.push_back({hi, s});
    end
    close();
  endtask : frame
  task automatic ones(input int n);
    logic [3:0] s;
    @(negedge clk);
    chipSelectN = 1'b0;
    for (int i = 0; i < n; i++) tick(4'hf, 1, 0, s);
    close();
  endtask : ones
endmodule : qspi_host_model

//--- verification/tb.sv
// self-checking bench for the quad-line read engine
`timescale 1ns/100ps
module tb;
  import qio_read_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic quadLinesEnableBit = 1'b1;
  logic loadEn = 1'b0;
  logic [9:0] loadAddr = 10'h000;
  logic [7:0] loadData = 8'h00;
  logic spiClk, chipSelectN, continuousModeActive, wrapDisableBit, readStreaming, sawDrive;
  logic [3:0] quadLineIn, quadLineOut, quadLineOe;
  logic [1:0] wrapLengthBits;
  logic [7:0] mem [1024];
  logic [31:0] lfsr = 32'h770f;
  logic [31:0] r, sz;
  int errors = 0, nChecks = 0, cyc = 0, wDis = 1, wLen = 0;
  logic [7:0] cmds [3] = '{CMD_FAST_QUAD_READ, CMD_WORD_QUAD_READ, CMD_OCTAL_QUAD_READ};
  logic [7:0] enders [3] = '{8'h00, 8'h1f, 8'hf3};
  always #50 clk = ~clk;
  quad_io_flash_read_engine #(.MEM_ADDR_BITS(10)) dut (.clk(clk), .srst(srst),
    .spiClk(spiClk), .chipSelectN(chipSelectN), .quadLineIn(quadLineIn),
    .quadLineOut(quadLineOut), .quadLineOe(quadLineOe), .quadLinesEnableBit(quadLinesEnableBit),
    .continuousModeActive(continuousModeActive), .wrapDisableBit(wrapDisableBit),
    .wrapLengthBits(wrapLengthBits), .readStreaming(readStreaming), .loadEn(loadEn),
    .loadAddr(loadAddr), .loadData(loadData));
  qspi_host_model host (.clk(clk), .devOut(quadLineOut), .devOe(quadLineOe), .spiClk(spiClk),
    .chipSelectN(chipSelectN), .lineIn(quadLineIn));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // wrap keeps the low bits inside the section
  function automatic logic [31:0] nxt(input logic [31:0] a);
    logic [31:0] m;
    m = (32'h8 << wLen) - 1;
    return wDis ? a + 1 : (a & ~m) | ((a + 1) & m);
  endfunction : nxt
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input bit useCmd, input logic [7:0] cmd, input logic [31:0] a,
      input logic [7:0] mode, input int nb);
    int d;
    d = (cmd == CMD_FAST_QUAD_READ) ? DUMMY_FAST_QUAD :
        (cmd == CMD_WORD_QUAD_READ) ? DUMMY_WORD_QUAD : DUMMY_OCTAL_QUAD;
    host.frame(useCmd, cmd, a[23:0], mode, d, nb);
    for (int i = 0; i < nb; i++) begin
      chk("data", mem[a[9:0]], host.got[i]);
      a = nxt(a);
    end
  endtask : rd
  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (quadLineOe != 4'h0) sawDrive = 1'b1;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] timeout expected %0d seen %0d", 39999, cyc);
      end_sim();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    chk("wrapDis", 1, wrapDisableBit);
    chk("wrapLen", 0, wrapLengthBits);
    chk("cont", 0, continuousModeActive);
    for (int i = 0; i < 1024; i++) begin
      r = rnd();
      mem[i] = r[7:0];
      loadAddr = i[9:0];
      loadData = r[7:0];
      loadEn = 1'b1;
      @(negedge clk);
    end
    loadEn = 1'b0;
    $display("test reset done");
    // aligned addresses, skip pair 10 then each other pair
    for (int k = 0; k < 3; k++) begin
      r = rnd() & ((k == 2) ? 32'hfffff0 : (k == 1) ? 32'hfffffe : 32'hffffff);
      rd(1, cmds[k], r, {r[31:30], 2'h2, r[27:24]}, 3);
      chk("cont", 1, continuousModeActive);
      rd(0, cmds[k], r + 32'h20, 8'ha5, 2);
      rd(0, cmds[k], r + 32'h40, enders[k], 2);
      chk("cont", 0, continuousModeActive);
    end
    $display("test continuous done");
    for (int n = 8; n <= 16; n += 8) begin
      rd(1, CMD_FAST_QUAD_READ, rnd(), 8'h20, 2);
      host.ones(n);
      chk("cont", 0, continuousModeActive);
      rd(1, CMD_FAST_QUAD_READ, rnd(), 8'h00, 2);
    end
    $display("test mode reset done");
    for (int w = 0; w < 4; w++) begin
      r = rnd();
      host.frame(1, CMD_SET_BURST_WRAP, r[23:0], {r[7], w[1:0], 1'b0, r[3:0]}, 0, 0);
      chk("wrapDis", 0, wrapDisableBit);
      chk("wrapLen", w, wrapLengthBits);
      wDis = 0;
      wLen = w;
      sz = 32'h8 << w;
      rd(1, CMD_FAST_QUAD_READ, (r & ~(sz - 1)) | (sz - 3), 8'h00, 5);
      rd(1, CMD_WORD_QUAD_READ, (r & ~(sz - 1)) | (sz - 2), 8'h00, 4);
    end
    host.frame(1, CMD_SET_BURST_WRAP, 24'h0, 8'h10, 0, 0);
    chk("wrapDis", 1, wrapDisableBit);
    wDis = 1;
    rd(1, CMD_FAST_QUAD_READ, 32'h3fd, 8'h00, 6);
    $display("test wrap done");
    quadLinesEnableBit = 1'b0;
    sawDrive = 1'b0;
    host.frame(1, CMD_FAST_QUAD_READ, 24'h10, 8'h00, 4, 2);
    chk("refused", 0, sawDrive);
    quadLinesEnableBit = 1'b1;
    $display("test quad enable done");
    // wrap on and skip mode set, then reset held over several edges mid-run
    host.frame(1, CMD_SET_BURST_WRAP, 24'h0, 8'h60, 0, 0);
    wDis = 0;
    wLen = 3;
    rd(1, CMD_FAST_QUAD_READ, 32'h7c, 8'h20, 6);
    chk("cont", 1, continuousModeActive);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    wDis = 1;
    chk("wrapDis", 1, wrapDisableBit);
    chk("wrapLen", 0, wrapLengthBits);
    chk("cont", 0, continuousModeActive);
    // crossing 0x3f shows the wrap is really off again
    rd(1, CMD_FAST_QUAD_READ, 32'h3e, 8'h00, 4);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb
